// ---- hdl/smc_cfg.svh ----
// Functional notes
// RL1 - a coil fault halts the motor on its own and switches both bridges off
// RL2 - a coil fault halt during motion sets the step loss flag
// RL3 - the host halt command stops the motor and switches the bridges off like a fault halt, without setting step loss
// RL4 - the zero position command clears actual and target position
// RL5 - the zero position command is ignored unless the motor rests
// RL6 - restore defaults overwrites every parameter with its reset value
// RL7 - restore defaults keeps actual position and copies it into target position
// RL8 - reference search loads velocities, seeks twice, zeroes, then goes to secure position
// RL9 - a running reference search is aborted only by shutdown or halt command
// RL10 - secure position 0x400 skips the last move of the reference search
// RL11 - host picks seek targets differing from actual position and each other
// RL12 - a stuck search is left only by halt then status readout, or by a coil fault shutdown
// RL13 - the parameter write command stores all listed motion parameters
// RL14 - secure position 0x400 disables every later safe position move
// RL15 - the jitter enable bit dithers the coil PWM frequency
// RL16 - the address byte is two ones, node address, hardwired bit, low write bit
// RL17 - second byte is the command code, filler bytes two and three are all ones
// RL18 - parameter payload sits in bytes four to eight in the fixed layout
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

`define SMC_CMD_HALT 8'h85
`define SMC_CMD_ZERO 8'h86
`define SMC_CMD_RESTORE 8'h87
`define SMC_CMD_REFSEARCH 8'h88
`define SMC_CMD_PARAM 8'h89
`define SMC_CMD_SAFE_MOVE 8'h84
`define SMC_CMD_STATUS1 8'h81
`define SMC_FILLER 8'hff
`define SMC_ADDR_TOP 2'h3
`define SMC_DIR_WRITE 1'h0
`define SMC_LEN_SHORT 5'h02
`define SMC_LEN_LONG 5'h09
`define SMC_FRAME_MAX 9
`define SMC_SECURE_POSITION_OFF 11'h400

`define SMC_DEF_RUN 4'h1
`define SMC_DEF_HOLD 4'h1
`define SMC_DEF_VMAX 4'h1
`define SMC_DEF_VMIN 4'h1
`define SMC_DEF_SECURE_POSITION 11'h400

`define SMC_STEP_FRAC 8'hff
`define SMC_PWM_SLOW 8'hc7
`define SMC_PWM_FAST 8'h63
`define SMC_LFSR_SEED 8'h5a

`define SMC_REG_CTRL 8'h00
`define SMC_REG_STATUS 8'h04
`define SMC_REG_IRQ_STAT 8'h08
`define SMC_REG_IRQ_MASK 8'h0c
`define SMC_REG_POS 8'h10
`define SMC_REG_PARAM0 8'h14
`define SMC_REG_PARAM1 8'h18

`define SMC_IRQ_FRAME 0
`define SMC_IRQ_HALT 1
`define SMC_IRQ_LOSS 2
`define SMC_IRQ_SEARCH 3
`define SMC_IRQ_W 4

`endif

// ---- hdl/smc_pkg.sv ----
`include "smc_cfg.svh"
package smc_pkg;

typedef struct packed {
    logic [3:0] run_current;
    logic [3:0] hold_current;
    logic [3:0] max_velocity;
    logic [3:0] min_velocity;
    logic ramp_profile;
    logic [1:0] step_resolution;
    logic direction_select;
    logic [3:0] ramp_rate;
    logic [10:0] secure_position;
    logic pwm_frequency_select;
    logic pwm_jitter_enable;
} smc_params_t;

typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [7:0] data;
} smc_rx_byte_t;

typedef enum logic [4:0] {
    SMC_RS_IDLE = 5'h01,
    SMC_RS_MOVE1 = 5'h02,
    SMC_RS_MOVE2 = 5'h04,
    SMC_RS_SECURE = 5'h08,
    SMC_RS_ABORT = 5'h10
} smc_rs_state_t;

localparam smc_params_t SMC_PARAMS_DEFAULT = '{
    run_current: `SMC_DEF_RUN,
    hold_current: `SMC_DEF_HOLD,
    max_velocity: `SMC_DEF_VMAX,
    min_velocity: `SMC_DEF_VMIN,
    ramp_profile: 1'b0,
    step_resolution: 2'h0,
    direction_select: 1'b0,
    ramp_rate: 4'h0,
    secure_position: `SMC_DEF_SECURE_POSITION,
    pwm_frequency_select: 1'b0,
    pwm_jitter_enable: 1'b0
};

endpackage

// ---- hdl/smc_link_rx.sv ----
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_link_rx
    import smc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output smc_rx_byte_t rx_byte,
    output logic frame_end
);

logic scl_meta, scl_s, scl_d;
logic sda_meta, sda_s, sda_d;
logic in_frame, next_in_frame;
logic ack, next_ack;
logic [3:0] bit_cnt, next_bit_cnt;
logic [3:0] index, next_index;
logic [7:0] shift, next_shift;
logic next_oe_n;
logic next_frame_end;
smc_rx_byte_t next_rx_byte;
logic scl_rise, scl_fall, start_cond, stop_cond;

assign scl_rise = scl_s & ~scl_d;
assign scl_fall = ~scl_s & scl_d;
assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

////////////////////////////////////////////////////////////////////////////////

always_comb begin
    next_in_frame = in_frame;
    next_ack = ack;
    next_bit_cnt = bit_cnt;
    next_index = index;
    next_shift = shift;
    next_oe_n = sda_oe_n;
    next_frame_end = 1'b0;
    next_rx_byte = '0;
    if (start_cond) begin
        next_in_frame = 1'b1;
        next_ack = 1'b0;
        next_bit_cnt = '0;
        next_index = '0;
        next_oe_n = 1'b1;
    end else if (stop_cond) begin
        next_in_frame = 1'b0;
        next_ack = 1'b0;
        next_oe_n = 1'b1;
        next_frame_end = in_frame;
    end else if (in_frame) begin
        if (scl_rise && bit_cnt < 4'h8) begin
            next_shift = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == 4'h7) begin
                next_rx_byte.valid = 1'b1;
                next_rx_byte.index = index;
                next_rx_byte.data = {shift[6:0], sda_s};
            end
        end else if (scl_fall && bit_cnt == 4'h8 && !ack) begin
            // pull data low through the acknowledge clock
            next_ack = 1'b1;
            next_oe_n = 1'b0;
        end else if (scl_fall && ack) begin
            next_ack = 1'b0;
            next_oe_n = 1'b1;
            next_bit_cnt = '0;
            if (index != 4'hf) begin
                next_index = index + 4'h1;
            end
        end
    end
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        scl_meta <= 1'b1;
        scl_s <= 1'b1;
        scl_d <= 1'b1;
        sda_meta <= 1'b1;
        sda_s <= 1'b1;
        sda_d <= 1'b1;
        in_frame <= 1'b0;
        ack <= 1'b0;
        bit_cnt <= '0;
        index <= '0;
        shift <= '0;
        sda_out <= 1'b0;
        sda_oe_n <= 1'b1;
        frame_end <= 1'b0;
        rx_byte <= '0;
    end else begin
        scl_meta <= scl_in;
        scl_s <= scl_meta;
        scl_d <= scl_s;
        sda_meta <= sda_in;
        sda_s <= sda_meta;
        sda_d <= sda_s;
        in_frame <= next_in_frame;
        ack <= next_ack;
        bit_cnt <= next_bit_cnt;
        index <= next_index;
        shift <= next_shift;
        sda_out <= 1'b0;
        sda_oe_n <= next_oe_n;
        frame_end <= next_frame_end;
        rx_byte <= next_rx_byte;
    end
end

endmodule

// ---- hdl/smc_top.sv ----
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_top
    import smc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic coil_fault,
    input wire logic hw_addr_pin,
    output logic bridge_en,
    output logic step_out,
    output logic dir_out,
    output logic pwm_out,
    output logic [3:0] coil_current,
    output logic [1:0] step_mode
);

logic [1:0] pin_meta, pin_sync;
logic fault_s, hw_bit;
smc_rx_byte_t rx_byte;
logic frame_end;
logic [7:0] frame [0:`SMC_FRAME_MAX-1];
logic [4:0] frame_len, next_frame_len;
smc_params_t params, next_params;
logic signed [15:0] act, next_act;
logic signed [15:0] tgt, next_tgt;
logic signed [15:0] seek2, next_seek2;
logic signed [15:0] secure_target;
smc_rs_state_t rs, next_rs;
logic started, next_started;
logic next_bridge, step_loss, next_loss;
logic [11:0] step_cnt, next_step_cnt;
logic next_step_out, next_dir_out;
logic [3:0] next_coil_current;
logic moving, step_tick, secure_off;
logic addr_ok, short_ok, long_ok;
logic [7:0] cmd;
logic [`SMC_IRQ_W-1:0] ev;
logic [7:0] pwm_cnt, next_pwm_cnt;
logic [7:0] lfsr, next_lfsr;
logic next_pwm_out;
logic [3:0] node_addr, next_node_addr;
logic [`SMC_IRQ_W-1:0] irq_stat, next_irq_stat;
logic [`SMC_IRQ_W-1:0] irq_mask, next_irq_mask;
logic [31:0] next_prdata;
logic next_pready, next_pslverr, next_irq;
logic apb_access, apb_done;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and serial receiver

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_meta <= '0;
        pin_sync <= '0;
    end else begin
        pin_meta <= {coil_fault, hw_addr_pin};
        pin_sync <= pin_meta;
    end
end

assign fault_s = pin_sync[1];
assign hw_bit = pin_sync[0];

smc_link_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .rx_byte(rx_byte),
    .frame_end(frame_end)
);

for (genvar i = 0; i < `SMC_FRAME_MAX; i++) begin : g_frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame[i] <= '0;
        end else if (rx_byte.valid && rx_byte.index == 4'(i)) begin
            frame[i] <= rx_byte.data;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// frame decode

assign cmd = frame[1];
assign addr_ok = frame[0][7:6] == `SMC_ADDR_TOP && frame[0][5:2] == node_addr
    && frame[0][1] == hw_bit && frame[0][0] == `SMC_DIR_WRITE; // [RL16]
assign short_ok = frame_len == `SMC_LEN_SHORT;
assign long_ok = frame_len == `SMC_LEN_LONG && frame[2] == `SMC_FILLER
    && frame[3] == `SMC_FILLER; // [RL17]
assign secure_off = params.secure_position == `SMC_SECURE_POSITION_OFF;
assign secure_target = {{5{params.secure_position[10]}}, params.secure_position};
assign moving = (act != tgt) && bridge_en;
assign step_tick = moving && step_cnt == '0;

////////////////////////////////////////////////////////////////////////////////
// motion and command state

always_comb begin
    next_frame_len = frame_len;
    next_params = params;
    next_act = act;
    next_tgt = tgt;
    next_seek2 = seek2;
    next_rs = rs;
    next_started = started;
    next_bridge = bridge_en;
    next_loss = step_loss;
    ev = '0;
    next_step_cnt = (step_cnt == '0) ? {~params.max_velocity, `SMC_STEP_FRAC} : step_cnt - 12'h001;
    if (rx_byte.valid) begin
        next_frame_len = 5'(rx_byte.index) + 5'h01;
    end
    if (step_tick) begin
        next_act = (tgt > act) ? act + 16'sh0001 : act - 16'sh0001;
        next_started = 1'b1;
    end
    // search moves advance when a move has run and come to rest; the secure move step needs rest only
    case (rs)
        SMC_RS_MOVE1: begin
            if (started && !moving) begin
                next_params.max_velocity = params.min_velocity; // [RL8]
                next_tgt = seek2; // [RL8]
                next_rs = SMC_RS_MOVE2;
                next_started = 1'b0;
            end
        end
        SMC_RS_MOVE2: begin
            if (started && !moving) begin
                next_act = '0; // [RL8]
                next_tgt = '0;
                next_started = 1'b0;
                if (secure_off) begin
                    next_rs = SMC_RS_IDLE; // [RL10]
                    ev[`SMC_IRQ_SEARCH] = 1'b1;
                end else begin
                    next_tgt = secure_target; // [RL8]
                    next_rs = SMC_RS_SECURE;
                end
            end
        end
        SMC_RS_SECURE: begin
            if (!moving) begin
                next_rs = SMC_RS_IDLE;
                ev[`SMC_IRQ_SEARCH] = 1'b1;
            end
        end
        default: begin
        end
    endcase
    if (frame_end && addr_ok) begin
        ev[`SMC_IRQ_FRAME] = 1'b1;
        if (short_ok && cmd == `SMC_CMD_HALT) begin
            next_tgt = next_act; // [RL3]
            next_bridge = 1'b0; // [RL3]
            ev[`SMC_IRQ_HALT] = 1'b1;
            if (rs != SMC_RS_IDLE) begin
                next_rs = SMC_RS_ABORT; // [RL9] [RL12]
            end
        end else if (short_ok && cmd == `SMC_CMD_STATUS1) begin
            next_loss = 1'b0;
            if (!fault_s) begin
                next_bridge = 1'b1;
            end
            if (rs == SMC_RS_ABORT) begin
                next_rs = SMC_RS_IDLE; // [RL12]
            end
        end else if (rs == SMC_RS_IDLE) begin // [RL9]
            if (short_ok && cmd == `SMC_CMD_ZERO) begin
                if (!moving) begin // [RL5]
                    next_act = '0; // [RL4]
                    next_tgt = '0; // [RL4]
                end
            end else if (short_ok && cmd == `SMC_CMD_RESTORE) begin
                next_params = SMC_PARAMS_DEFAULT; // [RL6]
                next_tgt = next_act; // [RL7]
            end else if (long_ok && cmd == `SMC_CMD_PARAM) begin
                next_params.run_current = frame[4][7:4]; // [RL13] [RL18]
                next_params.hold_current = frame[4][3:0];
                next_params.max_velocity = frame[5][7:4];
                next_params.min_velocity = frame[5][3:0];
                next_params.secure_position = {frame[6][7:5], frame[7]}; // [RL14]
                next_params.direction_select = frame[6][4];
                next_params.ramp_rate = frame[6][3:0];
                next_params.pwm_frequency_select = frame[8][6];
                next_params.ramp_profile = frame[8][4];
                next_params.step_resolution = frame[8][3:2];
                next_params.pwm_jitter_enable = frame[8][0];
            end else if (long_ok && cmd == `SMC_CMD_REFSEARCH && bridge_en) begin
                next_params.max_velocity = frame[4][7:4]; // [RL8]
                next_params.min_velocity = frame[4][3:0]; // [RL8]
                next_tgt = {frame[5], frame[6]}; // [RL8]
                next_seek2 = {frame[7], frame[8]};
                next_rs = SMC_RS_MOVE1;
                next_started = 1'b0;
            end else if (short_ok && cmd == `SMC_CMD_SAFE_MOVE) begin
                if (!secure_off && bridge_en) begin // [RL14]
                    next_tgt = secure_target;
                end
            end
        end
    end
    // coil fault: own halt, bridges off, search aborted as a shutdown
    if (fault_s && bridge_en) begin
        next_bridge = 1'b0; // [RL1]
        next_tgt = next_act; // [RL1]
        next_rs = SMC_RS_IDLE; // [RL9]
        ev[`SMC_IRQ_HALT] = 1'b1;
        if (moving) begin
            next_loss = 1'b1; // [RL2]
            ev[`SMC_IRQ_LOSS] = 1'b1;
        end
    end
    next_step_out = step_tick;
    next_dir_out = (tgt > act) ^ params.direction_select;
    next_coil_current = !next_bridge ? '0 : (moving ? params.run_current : params.hold_current);
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        frame_len <= '0;
        params <= SMC_PARAMS_DEFAULT;
        act <= '0;
        tgt <= '0;
        seek2 <= '0;
        rs <= SMC_RS_IDLE;
        started <= 1'b0;
        bridge_en <= 1'b1;
        step_loss <= 1'b0;
        step_cnt <= '0;
        step_out <= 1'b0;
        dir_out <= 1'b0;
        coil_current <= '0;
        step_mode <= '0;
    end else begin
        frame_len <= next_frame_len;
        params <= next_params;
        act <= next_act;
        tgt <= next_tgt;
        seek2 <= next_seek2;
        rs <= next_rs;
        started <= next_started;
        bridge_en <= next_bridge;
        step_loss <= next_loss;
        step_cnt <= next_step_cnt;
        step_out <= next_step_out;
        dir_out <= next_dir_out;
        coil_current <= next_coil_current;
        step_mode <= next_params.step_resolution;
    end
end

////////////////////////////////////////////////////////////////////////////////
// coil pwm base with optional period dither

always_comb begin
    next_pwm_cnt = pwm_cnt - 8'h01;
    next_lfsr = lfsr;
    next_pwm_out = pwm_out & bridge_en;
    if (pwm_cnt == '0) begin
        next_pwm_cnt = params.pwm_frequency_select ? `SMC_PWM_FAST : `SMC_PWM_SLOW;
        if (params.pwm_jitter_enable) begin
            next_pwm_cnt = next_pwm_cnt + {6'h00, lfsr[1:0]}; // [RL15]
        end
        next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        next_pwm_out = ~pwm_out & bridge_en;
    end
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pwm_cnt <= '0;
        lfsr <= `SMC_LFSR_SEED;
        pwm_out <= 1'b0;
    end else begin
        pwm_cnt <= next_pwm_cnt;
        lfsr <= next_lfsr;
        pwm_out <= next_pwm_out;
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave, one wait state per access

assign apb_access = psel && penable;
assign apb_done = apb_access && pready;

always_comb begin
    next_pready = apb_access && !pready;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_node_addr = node_addr;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (apb_access && !pready) begin
        next_prdata = '0;
        if (paddr == `SMC_REG_CTRL) begin
            next_prdata = {28'h0000000, node_addr};
        end else if (paddr == `SMC_REG_STATUS) begin
            next_prdata = {26'h0000000, fault_s, rs == SMC_RS_ABORT, rs != SMC_RS_IDLE,
                bridge_en, step_loss, moving};
        end else if (paddr == `SMC_REG_IRQ_STAT) begin
            next_prdata = {28'h0000000, irq_stat};
        end else if (paddr == `SMC_REG_IRQ_MASK) begin
            next_prdata = {28'h0000000, irq_mask};
        end else if (paddr == `SMC_REG_POS) begin
            next_prdata = {tgt, act};
        end else if (paddr == `SMC_REG_PARAM0) begin
            next_prdata = {params.secure_position, params.ramp_rate, params.direction_select,
                params.min_velocity, params.max_velocity, params.hold_current,
                params.run_current};
        end else if (paddr == `SMC_REG_PARAM1) begin
            next_prdata = {27'h0000000, params.pwm_jitter_enable, params.pwm_frequency_select,
                params.step_resolution, params.ramp_profile};
        end else begin
            next_pslverr = 1'b1;
        end
    end
    if (apb_done && pwrite) begin
        if (paddr == `SMC_REG_CTRL) begin
            next_node_addr = pwdata[3:0];
        end else if (paddr == `SMC_REG_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~pwdata[`SMC_IRQ_W-1:0];
        end else if (paddr == `SMC_REG_IRQ_MASK) begin
            next_irq_mask = pwdata[`SMC_IRQ_W-1:0];
        end
    end
    // new events win over a clear in the same cycle
    next_irq_stat = next_irq_stat | ev;
    next_irq = |(next_irq_stat & next_irq_mask);
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        prdata <= '0;
        pslverr <= 1'b0;
        node_addr <= '0;
        irq_stat <= '0;
        irq_mask <= '0;
        irq <= 1'b0;
    end else begin
        pready <= next_pready;
        prdata <= next_prdata;
        pslverr <= next_pslverr;
        node_addr <= next_node_addr;
        irq_stat <= next_irq_stat;
        irq_mask <= next_irq_mask;
        irq <= next_irq;
    end
end

endmodule

// ---- tb/smc_top_assertions.sv ----
`timescale 1ns/1ps
module smc_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic coil_fault,
    input wire logic bridge_en,
    input wire logic step_out,
    input wire logic [3:0] coil_current
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////
    property p_fault_halt;
        $rose(coil_fault) |-> ##[1:8] !bridge_en;
    endproperty
    a_fault_halt: assert property (p_fault_halt)
        else $error("bridges on after coil fault");
    property p_off_quiet;
        !bridge_en [*2] |-> !step_out && coil_current == 4'h0;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("motor driven with bridges off");
    property p_step_gap;
        step_out |=> !step_out [*8];
    endproperty
    a_step_gap: assert property (p_step_gap)
        else $error("steps too close");
    property p_ready_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("apb answer late");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    property p_err_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr outside access");
    property p_ack_scl;
        $changed(sda_oe_n) |-> !scl_in;
    endproperty
    a_ack_scl: assert property (p_ack_scl)
        else $error("sda changed while scl high");
    property p_pull_low;
        !sda_oe_n |-> !sda_out;
    endproperty
    a_pull_low: assert property (p_pull_low)
        else $error("sda driven high");
    c_fault: cover property ($fell(bridge_en));
    c_err: cover property (pslverr);
    c_step: cover property (step_out);
    c_ack: cover property (!sda_oe_n);
endmodule
////////////////////////////////
bind smc_top smc_top_chk u_chk (.*);

// ---- tb/smc_host_model.sv ----
`timescale 1ns/1ps
module smc_host_model (
    input wire logic pclk,
    output logic scl_in,
    output logic sda_drv
);
    initial begin
        scl_in = 1'b1;
        sda_drv = 1'b1;
    end
    ////////////////////////////////
    task automatic ph(input logic s, input logic d, input int k);
        scl_in <= s;
        sda_drv <= d;
        repeat (k) @(posedge pclk);
    endtask
    // scl idles high between frames; 125 ns bit period
    task automatic send(input logic [7:0] q[$]);
        ph(1'b1, 1'b0, 12);
        foreach (q[i]) begin
            for (int b = 7; b >= 0; b--) begin
                ph(1'b0, q[i][b], 13);
                ph(1'b1, q[i][b], 12);
            end
            ph(1'b0, 1'b1, 13);
            ph(1'b1, 1'b1, 12);
        end
        ph(1'b0, 1'b0, 13);
        ph(1'b1, 1'b0, 12);
        ph(1'b1, 1'b1, 12);
    endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`include "smc_cfg.svh"
module tb;
    localparam logic [7:0] node_byte = 8'hd6;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, scl_in, sda_drv;
    logic sda_out, sda_oe_n, coil_fault, hw_addr_pin, bridge_en, step_out, dir_out, pwm_out;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] coil_current;
    logic [1:0] step_mode;
    wire logic sda_in = sda_drv & (sda_oe_n | sda_out);
    int n_fail = 0;
    int cmp_count = 0;
    smc_top DUT (.*);
    smc_host_model host (.pclk(pclk), .scl_in(scl_in), .sda_drv(sda_drv));
    ////////////////////////////////
    task automatic results();
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            results();
        end
        rd = prdata;
        chk("pslverr", 32'(pslverr), 32'(e));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(n, rd, e);
    endtask
    task automatic settle();
        int k;
        k = 0;
        do begin
            repeat (50) @(posedge pclk);
            apb(1'b0, 8'h04, 32'h0, 1'b0);
            k++;
        end while ((rd[0] | rd[3]) !== 1'b0 && k < 400);
        if (k >= 400) begin
            n_fail++;
            results();
        end
    endtask
    task automatic cmd(input logic [7:0] q[$]);
        host.send(q);
        repeat (10) @(posedge pclk);
    endtask
    task automatic sh(input logic [7:0] c);
        cmd('{node_byte, c});
    endtask
    task automatic prm(input logic [7:0] a, input logic [7:0] hi, input logic [7:0] lo);
        cmd('{a, `SMC_CMD_PARAM, 8'hff, 8'hff, 8'h32, 8'hfe, hi, lo, 8'hfb});
    endtask
    task automatic srch(input logic [15:0] p1, input logic [15:0] p2);
        cmd('{node_byte, `SMC_CMD_REFSEARCH, 8'hff, 8'hff, 8'hff, p1[15:8], p1[7:0],
            p2[15:8], p2[7:0]});
    endtask
    ////////////////////////////////
    task automatic s_regs();
        apb(1'b1, 8'h00, 32'h5, 1'b0);
        rdc(8'h00, 32'h5, "ctrl");
        rdc(8'h0c, 32'h0, "irq_mask");
        rdc(8'h14, 32'h80001111, "param0 reset");
        apb(1'b0, 8'h1c, 32'h0, 1'b1);
        chk("unmapped", rd, 32'h0);
    endtask
    task automatic s_param();
        prm(8'hd4, 8'h05, 8'h10);
        rdc(8'h14, 32'h80001111, "other node");
        prm(node_byte, 8'h05, 8'h10);
        rdc(8'h14, 32'h020aef23, "param0");
        rdc(8'h18, 32'h1d, "param1");
        chk("step_mode", 32'(step_mode), 32'h2);
    endtask
    task automatic s_search();
        apb(1'b1, 8'h0c, 32'h8, 1'b0);
        srch(16'h0003, 16'h0001);
        sh(`SMC_CMD_RESTORE);
        settle();
        rdc(8'h10, 32'h00100010, "pos after search");
        rdc(8'h14, 32'h020aff23, "param0 after search");
        chk("irq", 32'(irq), 32'h1);
        apb(1'b1, 8'h08, 32'h8, 1'b0);
        chk("irq cleared", 32'(irq), 32'h0);
    endtask
    task automatic s_restore();
        sh(`SMC_CMD_RESTORE);
        rdc(8'h14, 32'h80001111, "param0 restored");
        rdc(8'h10, 32'h00100010, "pos kept");
    endtask
    task automatic s_skip();
        prm(node_byte, 8'h85, 8'h00);
        srch(16'h0013, 16'h0012);
        settle();
        rdc(8'h10, 32'h0, "pos no secure move");
        sh(`SMC_CMD_SAFE_MOVE);
        settle();
        rdc(8'h10, 32'h0, "safe move disabled");
        srch(16'h0, 16'h1);
        sh(`SMC_CMD_HALT);
        rdc(8'h04, 32'h18, "stuck");
        sh(`SMC_CMD_STATUS1);
    endtask
    task automatic s_halt();
        prm(node_byte, 8'h05, 8'h10);
        sh(`SMC_CMD_SAFE_MOVE);
        sh(`SMC_CMD_ZERO);
        rdc(8'h04, 32'h5, "moving status");
        chk("dir", 32'(dir_out), 32'h1);
        apb(1'b0, 8'h10, 32'h0, 1'b0);
        chk("tgt moving", 32'(rd[31:16]), 32'h10);
        sh(`SMC_CMD_HALT);
        apb(1'b0, 8'h10, 32'h0, 1'b0);
        chk("target after halt", 32'(rd[31:16]), 32'(rd[15:0]));
        chk("bridge after halt", 32'(bridge_en), 32'h0);
        sh(`SMC_CMD_STATUS1);
        sh(`SMC_CMD_ZERO);
        rdc(8'h10, 32'h0, "pos zeroed");
    endtask
    task automatic s_fault();
        sh(`SMC_CMD_SAFE_MOVE);
        coil_fault <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("bridge on fault", 32'(bridge_en), 32'h0);
        chk("current on fault", 32'(coil_current), 32'h0);
        chk("pwm", 32'(pwm_out), 32'h0);
        apb(1'b0, 8'h04, 32'h0, 1'b0);
        chk("step loss", 32'(rd[1]), 32'h1);
        coil_fault <= 1'b0;
        repeat (5) @(posedge pclk);
        sh(`SMC_CMD_STATUS1);
        apb(1'b0, 8'h04, 32'h0, 1'b0);
        chk("readout", 32'(rd[2:1]), 32'h2);
    endtask
    ////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        coil_fault = 1'b0;
        hw_addr_pin = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        s_regs();
        s_param();
        s_search();
        s_restore();
        s_skip();
        s_halt();
        s_fault();
        results();
    end
endmodule
